// file: pkg/thermo_link_map.svh
/*
 constants for the single-wire sensor link: opcodes, scratchpad layout, timing.
 assumes a 125 MHz core clock; included by design files by bare name.
*/
`ifndef THERMO_LINK_MAP_SVH
`define THERMO_LINK_MAP_SVH

`define CLK_MHZ 125
`define OP_CONVERT 8'h44
`define OP_RD_PAD 8'hBE
`define OP_WR_PAD 8'h4E
`define OP_COPY 8'h48
`define OP_RECALL 8'hB8
`define PAD_BYTES 9
`define PAD_TH 2
`define PAD_TL 3
`define PAD_CFG 4
`define PAD_CRC 8
`define PAD_LAST 4'h8
`define RESET_US 480
`define PRES_WAIT_US 30
`define PRES_LOW_US 120
`define WR_SAMPLE_US 30
`define RD_HOLD_US 15
`define RESET_CYC (`RESET_US * `CLK_MHZ)
`define PRES_WAIT_CYC (`PRES_WAIT_US * `CLK_MHZ)
`define PRES_LOW_CYC (`PRES_LOW_US * `CLK_MHZ)
`define WR_SAMPLE_CYC (`WR_SAMPLE_US * `CLK_MHZ)
`define RD_HOLD_CYC (`RD_HOLD_US * `CLK_MHZ)
`define CNT_W 17
`define NV_BUSY_CYC 200
`define CFG_RESET 8'h7F

`endif

// file: pkg/thermo_link_pkg.sv
/*
 types for the single-wire sensor link.
 assumes nothing beyond the map header.
*/
`default_nettype none
package thermo_link_pkg;
   typedef enum logic [2:0] {
      ph_idle, ph_reset_wait, ph_pres_wait, ph_pres_low, ph_slot
   } line_phase_t;
   typedef enum logic [2:0] {
      cmd_rom, cmd_op, cmd_wr_pad, cmd_rd_pad, cmd_recall, cmd_quiet, cmd_done
   } cmd_state_t;
endpackage
`default_nettype wire

// file: verilog/byte_fifo.sv
/*
 small synchronous FIFO in flip-flops, valid/ready both sides.
 assumes one clock and a synchronous active-high clear plus async low reset.
*/
`default_nettype none
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   input wire logic clear,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [AW:0] count;
   logic push;
   logic pop;

   assign in_ready = (count != (AW+1)'(DEPTH));
   assign out_valid = (count != '0);
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_ptr];

   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else if (clear) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // byte_fifo
`default_nettype wire

// file: verilog/thermo_link_slave.sv
/*
 slave end of a single-wire parasite-powered temperature sensor link:
 reset/presence, write and read slots, function opcodes, recall and copy.
 assumes the open-drain line is resolved outside (dq_in, dq_out, dq_oe);
 the addressing layer above has selected this device: rom_done pulses
 when a function opcode is expected next. temperature bytes come in on
 ports; the nonvolatile store is modelled in flip-flops here.
*/
`default_nettype none
`include "thermo_link_map.svh"
// Contract
// - recall loads triggers and config into bytes 2-4
// - recall status: read 0 busy, 1 done
// - recall runs by itself after power-up
// - read opcode sends nine bytes ending CRC
// - write opcode stores three bytes into 2-4
// - copy stores bytes 2-4 nonvolatile, silent
// - no bus activity during convert or copy
// - reset pulse aborts any transfer
// - master starts all slots except presence
// - presence waits 15-60 us, lasts 60-240
// - sample written bit 15-60 us after fall
// - drive data only in master read slots
// - read 1 released, read 0 pulled low
// - read data held 15 us after fall
// - bytes go least significant bit first
// - scratchpad read starts byte 0 LSB
module thermo_link_slave #(
   parameter int RESET_CYC = `RESET_CYC,
   parameter int PRES_WAIT_CYC = `PRES_WAIT_CYC,
   parameter int PRES_LOW_CYC = `PRES_LOW_CYC,
   parameter int WR_SAMPLE_CYC = `WR_SAMPLE_CYC,
   parameter int RD_HOLD_CYC = `RD_HOLD_CYC,
   parameter int NV_BUSY_CYC = `NV_BUSY_CYC,
   parameter int FIFO_DEPTH = 16
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // data line
   input wire logic dq_in,
   output logic dq_out,
   output logic dq_oe,
   // addressing layer
   input wire logic rom_done,
   output logic rom_start,
   // sensor core
   input wire logic [7:0] temp_lsb,
   input wire logic [7:0] temp_msb,
   input wire logic [7:0] pad_crc,
   input wire logic conv_busy,
   output logic conv_start,
   // scratchpad view
   output logic [7:0] trig_high,
   output logic [7:0] trig_low,
   output logic [7:0] config_byte,
   output logic nv_busy
);
   logic [1:0] rst_sync;
   logic rst_n;
   logic [2:0] dq_sync;
   logic dq_s;
   logic dq_prev;
   logic fall;
   logic rise;
   logic [`CNT_W-1:0] cnt;
   thermo_link_pkg::line_phase_t phase;
   thermo_link_pkg::cmd_state_t cmd;
   logic bit_valid;
   logic bit_val;
   logic [7:0] shreg;
   logic [2:0] bit_idx;
   logic [3:0] byte_idx;
   logic [1:0] wr_cnt;
   logic tx_bit;
   logic tx_low;
   logic tx_active;
   logic [7:0] nv_th;
   logic [7:0] nv_tl;
   logic [7:0] nv_cfg;
   logic [$clog2(NV_BUSY_CYC+1)-1:0] nv_cnt;
   logic nv_recall;
   logic nv_copy;
   logic boot_recall;
   logic byte_done;
   logic fifo_valid;
   logic fifo_ready;
   logic [7:0] fifo_data;
   logic [7:0] rx_byte;
   logic bus_reset;

   function automatic logic [7:0] pad_byte(input logic [3:0] idx);
      case (idx)
         4'h0: pad_byte = temp_lsb;
         4'h1: pad_byte = temp_msb;
         4'h2: pad_byte = trig_high;
         4'h3: pad_byte = trig_low;
         4'h4: pad_byte = config_byte;
         `PAD_LAST: pad_byte = pad_crc;
         default: pad_byte = 8'hFF;
      endcase
   endfunction

   // reset release
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rst_sync <= 2'h0;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   // line synchroniser, change accepted once stages 2 and 3 agree
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         dq_sync <= 3'h7;
         dq_s <= 1'b1;
         dq_prev <= 1'b1;
      end else begin
         dq_sync <= {dq_sync[1:0], dq_in};
         if (dq_sync[2] == dq_sync[1]) begin
            dq_s <= dq_sync[2];
         end
         dq_prev <= dq_s;
      end
   end
   assign fall = dq_prev && !dq_s;
   assign rise = !dq_prev && dq_s;

   // slot timer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= '0;
      end else if ((fall && phase == thermo_link_pkg::ph_idle) ||
            (rise && phase == thermo_link_pkg::ph_reset_wait)) begin
         cnt <= '0;
      end else if (cnt != {`CNT_W{1'b1}}) begin
         cnt <= cnt + 1'b1;
      end
   end

   // a long low is seen after the slot sample has already gone back to idle
   assign bus_reset = ((phase == thermo_link_pkg::ph_slot) ||
      (phase == thermo_link_pkg::ph_idle)) && !dq_s &&
      (cnt == `CNT_W'(RESET_CYC));

   // line phase: reset, presence, slots
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         phase <= thermo_link_pkg::ph_idle;
         bit_valid <= 1'b0;
         bit_val <= 1'b0;
      end else begin
         bit_valid <= 1'b0;
         unique case (phase)
            thermo_link_pkg::ph_idle: begin
               if (bus_reset) begin
                  phase <= thermo_link_pkg::ph_reset_wait;
               end else if (fall) begin
                  phase <= thermo_link_pkg::ph_slot;
               end
            end
            thermo_link_pkg::ph_slot: begin
               if (bus_reset) begin
                  phase <= thermo_link_pkg::ph_reset_wait;
               end else if (cnt == `CNT_W'(WR_SAMPLE_CYC) && !tx_active) begin
                  bit_valid <= 1'b1;
                  bit_val <= dq_s;
                  phase <= thermo_link_pkg::ph_idle;
               end else if (cnt == `CNT_W'(RD_HOLD_CYC) && tx_active) begin
                  bit_valid <= 1'b1;
                  phase <= thermo_link_pkg::ph_idle;
               end
            end
            thermo_link_pkg::ph_reset_wait: begin
               if (rise) begin
                  phase <= thermo_link_pkg::ph_pres_wait;
               end
            end
            thermo_link_pkg::ph_pres_wait: begin
               if (cnt == `CNT_W'(PRES_WAIT_CYC)) begin
                  phase <= thermo_link_pkg::ph_pres_low;
               end
            end
            thermo_link_pkg::ph_pres_low: begin
               if (cnt == `CNT_W'(PRES_WAIT_CYC + PRES_LOW_CYC)) begin
                  phase <= thermo_link_pkg::ph_idle;
               end
            end
            default: phase <= thermo_link_pkg::ph_idle;
         endcase
      end
   end

   // presence counted from the rise; own pull must not restart the timer
   assign tx_active = (cmd == thermo_link_pkg::cmd_rd_pad) ||
      (cmd == thermo_link_pkg::cmd_recall);
   assign tx_low = (phase == thermo_link_pkg::ph_slot) && tx_active && !tx_bit &&
      (cnt < `CNT_W'(RD_HOLD_CYC));
   always_comb begin
      dq_out = 1'b0;
      dq_oe = (phase == thermo_link_pkg::ph_pres_low) || tx_low;
   end

   // transmit bit source
   always_comb begin
      if (cmd == thermo_link_pkg::cmd_recall) begin
         tx_bit = !nv_busy;
      end else begin
         tx_bit = shreg[0];
      end
   end

   assign byte_done = bit_valid && (bit_idx == 3'h7);
   assign rx_byte = {bit_val, shreg[7:1]};
   assign rom_start = (phase == thermo_link_pkg::ph_pres_low) &&
      (cnt == `CNT_W'(PRES_WAIT_CYC + PRES_LOW_CYC));

   // command layer
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmd <= thermo_link_pkg::cmd_done;
         shreg <= 8'h00;
         bit_idx <= 3'h0;
         byte_idx <= 4'h0;
         wr_cnt <= 2'h0;
         conv_start <= 1'b0;
         nv_copy <= 1'b0;
         nv_recall <= 1'b0;
      end else begin
         conv_start <= 1'b0;
         nv_copy <= 1'b0;
         nv_recall <= 1'b0;
         if (bus_reset) begin
            cmd <= thermo_link_pkg::cmd_rom;
            bit_idx <= 3'h0;
         end else if (rom_done && cmd == thermo_link_pkg::cmd_rom) begin
            cmd <= thermo_link_pkg::cmd_op;
            bit_idx <= 3'h0;
         end else if (bit_valid) begin
            bit_idx <= bit_idx + 1'b1;
            unique case (cmd)
               thermo_link_pkg::cmd_op: begin
                  shreg <= rx_byte;
                  if (byte_done) begin
                     byte_idx <= 4'h0;
                     wr_cnt <= 2'h0;
                     if (rx_byte == `OP_CONVERT) begin
                        conv_start <= 1'b1;
                        cmd <= thermo_link_pkg::cmd_quiet;
                     end else if (rx_byte == `OP_COPY) begin
                        nv_copy <= 1'b1;
                        cmd <= thermo_link_pkg::cmd_quiet;
                     end else if (rx_byte == `OP_WR_PAD) begin
                        cmd <= thermo_link_pkg::cmd_wr_pad;
                     end else if (rx_byte == `OP_RD_PAD) begin
                        shreg <= pad_byte(4'h0);
                        cmd <= thermo_link_pkg::cmd_rd_pad;
                     end else if (rx_byte == `OP_RECALL) begin
                        nv_recall <= 1'b1;
                        cmd <= thermo_link_pkg::cmd_recall;
                     end else begin
                        cmd <= thermo_link_pkg::cmd_done;
                     end
                  end
               end
               thermo_link_pkg::cmd_wr_pad: begin
                  shreg <= rx_byte;
                  if (byte_done) begin
                     wr_cnt <= wr_cnt + 1'b1;
                     if (wr_cnt == 2'h2) begin
                        cmd <= thermo_link_pkg::cmd_done;
                     end
                  end
               end
               thermo_link_pkg::cmd_rd_pad: begin
                  if (byte_done) begin
                     byte_idx <= byte_idx + 1'b1;
                     shreg <= pad_byte(byte_idx + 1'b1);
                     if (byte_idx == `PAD_LAST) begin
                        cmd <= thermo_link_pkg::cmd_done;
                     end
                  end else begin
                     shreg <= {1'b1, shreg[7:1]};
                  end
               end
               default: begin
               end
            endcase
         end
      end
   end

   // write bytes queue up ahead of the scratchpad
   byte_fifo #(
      .WIDTH(8),
      .DEPTH(FIFO_DEPTH)
   ) u_wr_fifo (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .clear(1'b0),
      .in_valid(byte_done && cmd == thermo_link_pkg::cmd_wr_pad),
      .in_ready(),
      .in_data(rx_byte),
      .out_valid(fifo_valid),
      .out_ready(fifo_ready),
      .out_data(fifo_data)
   );
   assign fifo_ready = !nv_busy;

   // scratchpad trigger/config bytes and nonvolatile store
   logic [1:0] pad_slot;
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         trig_high <= 8'h00;
         trig_low <= 8'h00;
         config_byte <= `CFG_RESET;
         nv_th <= 8'h00;
         nv_tl <= 8'h00;
         nv_cfg <= `CFG_RESET;
         nv_cnt <= '0;
         boot_recall <= 1'b1;
         pad_slot <= 2'h0;
      end else begin
         boot_recall <= 1'b0;
         if (bus_reset || (cmd == thermo_link_pkg::cmd_op)) begin
            pad_slot <= 2'h0;
         end
         if (fifo_valid && fifo_ready) begin
            pad_slot <= pad_slot + 1'b1;
            unique case (pad_slot)
               2'h0: trig_high <= fifo_data;
               2'h1: trig_low <= fifo_data;
               default: config_byte <= fifo_data;
            endcase
         end
         if (nv_recall || boot_recall) begin
            nv_cnt <= NV_BUSY_CYC[$bits(nv_cnt)-1:0];
         end else if (nv_copy) begin
            nv_cnt <= NV_BUSY_CYC[$bits(nv_cnt)-1:0];
            nv_th <= trig_high;
            nv_tl <= trig_low;
            nv_cfg <= config_byte;
         end else if (nv_cnt != '0) begin
            nv_cnt <= nv_cnt - 1'b1;
            if (nv_cnt == 1 && cmd != thermo_link_pkg::cmd_quiet) begin
               trig_high <= nv_th;
               trig_low <= nv_tl;
               config_byte <= nv_cfg;
            end
         end
      end
   end
   assign nv_busy = (nv_cnt != '0) || boot_recall;
endmodule // thermo_link_slave
`default_nettype wire

// file: test/thermo_link_slave_assertions.sv
/*
 port checker for the sensor link slave.
 assumes it is bound onto thermo_link_slave and shares its counts.
*/
`default_nettype none
module thermo_link_checker #(
   parameter int RESET_CYC = 60,
   parameter int PRES_LOW_CYC = 40,
   parameter int NV_BUSY_CYC = 200
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // data line
   input wire logic dq_in,
   input wire logic dq_out,
   input wire logic dq_oe,
   // status
   input wire logic rom_start,
   input wire logic conv_start,
   input wire logic nv_busy
);
   int low_cnt;
   int fall_cnt;
   int oe_cnt;
   int last_run;
   int busy_cnt;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   // line history: low run and time since last fall
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         low_cnt <= 0;
         fall_cnt <= 0;
      end else begin
         low_cnt <= dq_in ? 0 : low_cnt + 1;
         fall_cnt <= $fell(dq_in) ? 0 : (fall_cnt < 1000 ? fall_cnt + 1 : fall_cnt);
      end
   end
   // pull and busy run lengths
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         oe_cnt <= 0;
         last_run <= 0;
         busy_cnt <= 0;
      end else begin
         oe_cnt <= dq_oe ? oe_cnt + 1 : 0;
         if (!dq_oe && oe_cnt != 0) begin
            last_run <= oe_cnt;
         end
         busy_cnt <= nv_busy ? busy_cnt + 1 : 0;
      end
   end
   sequence reset_end;
      $rose(dq_in) && low_cnt >= RESET_CYC;
   endsequence
   sequence pres_pulse;
      !dq_oe [*8] ##[8:30] dq_oe;
   endsequence
   AST_OPEN_DRAIN: assert property (dq_out == 1'b0)
      else $error("line driven high");
   AST_OE_MIN: assert property ($rose(dq_oe) |-> dq_oe [*8])
      else $error("pull released too early");
   AST_OE_MAX: assert property (oe_cnt <= PRES_LOW_CYC + 2)
      else $error("pull held too long");
   AST_OE_CAUSE: assert property ($rose(dq_oe) |-> fall_cnt < RESET_CYC + 90)
      else $error("pull without a master slot");
   AST_PRES_AFTER_RESET: assert property (reset_end |-> pres_pulse)
      else $error("presence missing or mistimed");
   AST_ROM_START: assert property (rom_start |->
      (oe_cnt >= PRES_LOW_CYC - 2 || last_run >= PRES_LOW_CYC - 2))
      else $error("addressing start without presence");
   AST_CONV_PULSE: assert property (conv_start |-> !dq_oe ##1 !conv_start)
      else $error("convert start not a quiet single pulse");
   AST_NV_BOUND: assert property (busy_cnt <= NV_BUSY_CYC + 4)
      else $error("nonvolatile operation overruns");
endmodule // thermo_link_checker
bind thermo_link_slave thermo_link_checker #(.RESET_CYC(RESET_CYC),
   .PRES_LOW_CYC(PRES_LOW_CYC), .NV_BUSY_CYC(NV_BUSY_CYC)) u_checker (
   .core_clk(core_clk), .rstn(rstn), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
   .rom_start(rom_start), .conv_start(conv_start), .nv_busy(nv_busy));
`default_nettype wire

// file: test/line_master.sv
/*
 behavioural single-wire bus master driving the shared line low.
 assumes a pullup resolves the line outside; tasks start just after a rising edge.
*/
`default_nettype none
module line_master #(
   parameter int RESET_CYC = 60
) (
   // clock
   input wire logic core_clk,
   // line
   input wire logic line,
   output logic pull_low
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pull_low = 1'b0;
   task automatic wait_clk(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // line left high through convert and copy
   task automatic hold_high(input int n);
      wait_clk(n);
   endtask
   task automatic bus_reset(output int dly, output int wid);
      pull_low <= 1'b1;
      wait_clk(RESET_CYC + 10);
      pull_low <= 1'b0;
      dly = 0;
      wid = 0;
      @(negedge core_clk);
      while (line && dly < 100) begin
         dly++;
         @(negedge core_clk);
      end
      while (!line && wid < 100) begin
         wid++;
         @(negedge core_clk);
      end
      wait_clk(10);
   endtask
   // a 1 slot doubles as a read slot; its low outlasts the device's sync delay
   task automatic slot(input logic b, output logic r);
      r = 1'b1;
      pull_low <= 1'b1;
      wait_clk(b ? 8 : 40);
      pull_low <= 1'b0;
      if (b) begin
         wait_clk(4);
         @(negedge core_clk);
         r = line;
      end
      wait_clk(b ? 40 : 8);
   endtask
   task automatic send_byte(input logic [7:0] v);
      logic r;
      for (int i = 0; i < 8; i++) slot(v[i], r);
   endtask
   task automatic get_byte(output logic [7:0] v);
      logic r;
      for (int i = 0; i < 8; i++) begin
         slot(1'b1, r);
         v[i] = r;
      end
   endtask
endmodule // line_master
`default_nettype wire

// file: test/tb_thermo_link_slave.sv
/*
 testbench for the sensor link slave with a master model on the line.
 assumes shortened counts and constant sensor bytes, except temp_lsb, which the read test changes once.
*/
`default_nettype none
`define CHECK(name, exp, got) begin num_checks++; if ((got) !== (exp)) begin \
   miscompares++; $display("Error %s expected %h seen %h", name, exp, got); end end
module tb_thermo_link_slave;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int RST_CYC = 60;
   localparam int PW_CYC = 20;
   localparam int PL_CYC = 40;
   localparam int WS_CYC = 20;
   localparam int RH_CYC = 10;
   localparam int NVB_CYC = 200;
   logic core_clk = 1'b0;
   logic [7:0] temp_lsb = 8'h5A;
   logic [7:0] temp_msb = 8'hC3;
   logic [7:0] pad_crc = 8'h96;
   logic conv_busy = 1'b0;
   logic rstn = 1'b0;
   logic rom_done = 1'b0;
   logic dq_oe;
   logic dq_out;
   logic pull_low;
   logic rom_start;
   logic conv_start;
   logic nv_busy;
   logic [7:0] trig_high;
   logic [7:0] trig_low;
   logic [7:0] config_byte;
   logic [7:0] rd [9];
   logic r;
   wire logic dq_line;
   int miscompares = 0;
   int num_checks = 0;
   int cycles = 0;
   int conv_cnt = 0;
   int oe_cnt = 0;
   int dly;
   int wid;
   assign dq_line = !(pull_low || dq_oe);
   always #4 core_clk = ~core_clk;
   thermo_link_slave #(.RESET_CYC(RST_CYC), .PRES_WAIT_CYC(PW_CYC), .PRES_LOW_CYC(PL_CYC),
      .WR_SAMPLE_CYC(WS_CYC), .RD_HOLD_CYC(RH_CYC), .NV_BUSY_CYC(NVB_CYC)) u_dut (
      .core_clk(core_clk), .rstn(rstn), .dq_in(dq_line), .dq_out(dq_out), .dq_oe(dq_oe),
      .rom_done(rom_done), .rom_start(rom_start), .temp_lsb(temp_lsb), .temp_msb(temp_msb),
      .pad_crc(pad_crc), .conv_busy(conv_busy), .conv_start(conv_start), .trig_high(trig_high),
      .trig_low(trig_low), .config_byte(config_byte), .nv_busy(nv_busy));
   line_master #(.RESET_CYC(RST_CYC)) u_master (
      .core_clk(core_clk), .line(dq_line), .pull_low(pull_low));
   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(negedge core_clk) begin
      cycles++;
      conv_cnt += conv_start;
      oe_cnt += dq_oe;
      if (cycles == 30000) begin
         miscompares++;
         complete_run();
      end
   end
   task automatic open_op(input logic [7:0] op);
      u_master.bus_reset(dly, wid);
      `CHECK("presence delay", 1'b1, dly inside {[20:28]})
      `CHECK("presence width", 1'b1, wid inside {[38:42]})
      rom_done <= 1'b1;
      @(posedge core_clk);
      rom_done <= 1'b0;
      @(posedge core_clk);
      u_master.send_byte(op);
   endtask
   task automatic wr_pad(input logic [7:0] th, input logic [7:0] tl, input logic [7:0] cf);
      open_op(8'h4E);
      u_master.send_byte(th);
      u_master.send_byte(tl);
      u_master.send_byte(cf);
      repeat (2) @(posedge core_clk);
      `CHECK("high trigger", th, trig_high)
      `CHECK("low trigger", tl, trig_low)
      `CHECK("config", cf, config_byte)
   endtask
   task automatic t_power;
      repeat (4) @(negedge core_clk);
      `CHECK("busy at power-up", 1'b1, nv_busy)
      for (int i = 0; i < 400 && nv_busy !== 1'b0; i++) @(negedge core_clk);
      `CHECK("recall finished", 1'b0, nv_busy)
      `CHECK("config", 8'h7F, config_byte)
      `CHECK("high trigger", 8'h00, trig_high)
      @(posedge core_clk);
      $display("test power-up recall done");
   endtask
   task automatic t_read;
      wr_pad(8'hA5, 8'h3C, 8'h81);
      open_op(8'hBE);
      for (int i = 0; i < 9; i++) u_master.get_byte(rd[i]);
      `CHECK("byte 0", 8'h5A, rd[0])
      `CHECK("byte 1", 8'hC3, rd[1])
      `CHECK("byte 2", 8'hA5, rd[2])
      `CHECK("byte 3", 8'h3C, rd[3])
      `CHECK("byte 4", 8'h81, rd[4])
      `CHECK("crc byte", 8'h96, rd[8])
      open_op(8'hBE);
      u_master.get_byte(rd[0]);
      u_master.slot(1'b1, r);
      temp_lsb <= 8'hE1;
      open_op(8'hBE);
      u_master.get_byte(rd[1]);
      `CHECK("byte 0 after abort", 8'hE1, rd[1])
      $display("test scratchpad read done");
   endtask
   task automatic t_nv;
      int n;
      open_op(8'h48);
      oe_cnt = 0;
      repeat (4) @(posedge core_clk);
      `CHECK("copy busy", 1'b1, nv_busy)
      u_master.hold_high(300);
      `CHECK("pulls during copy", 0, oe_cnt)
      wr_pad(8'h01, 8'h02, 8'h03);
      open_op(8'hB8);
      u_master.slot(1'b1, r);
      `CHECK("recall busy bit", 1'b0, r)
      n = 0;
      while (r !== 1'b1 && n < 12) begin
         u_master.slot(1'b1, r);
         n++;
      end
      `CHECK("recall done bit", 1'b1, r)
      `CHECK("high trigger", 8'hA5, trig_high)
      `CHECK("low trigger", 8'h3C, trig_low)
      `CHECK("config", 8'h81, config_byte)
      $display("test copy and recall done");
   endtask
   task automatic t_quiet;
      logic [7:0] ops [2] = '{8'h44, 8'h12};
      int c0;
      for (int k = 0; k < 2; k++) begin
         c0 = conv_cnt;
         open_op(ops[k]);
         repeat (4) @(posedge core_clk);
         `CHECK("convert starts", (k == 0) ? 1 : 0, conv_cnt - c0)
         oe_cnt = 0;
         u_master.get_byte(rd[0]);
         `CHECK("silent line", 8'hFF, rd[0])
         `CHECK("pulls when silent", 0, oe_cnt)
      end
      $display("test quiet opcodes done");
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      rstn <= 1'b1;
      t_power;
      t_read;
      t_nv;
      t_quiet;
      complete_run();
   end
endmodule // tb_thermo_link_slave
`default_nettype wire
